// [verilog/kpm_params.svh]
// Constants of the keypad parameter menu: timing, widths and setting codes.
`ifndef KPM_PARAMS_SVH
`define KPM_PARAMS_SVH

`define KPM_CLK_MHZ 100
`define KPM_DEBOUNCE_US 2000
`define KPM_DEBOUNCE_CYC (`KPM_DEBOUNCE_US * `KPM_CLK_MHZ)
`define KPM_CHORD_US 50000
`define KPM_CHORD_CYC (`KPM_CHORD_US * `KPM_CLK_MHZ)
`define KPM_BLINK_US 250000
`define KPM_BLINK_CYC (`KPM_BLINK_US * `KPM_CLK_MHZ)
`define KPM_NUM_PARAMS 999
`define KPM_VAL_W 16
`define KPM_FREQ_W 16
`define KPM_POS_W 8
`define KPM_SET_W 8
`define KPM_SRC_TERM_KBD 8'h00
`define KPM_POT_FUNC_FREQ 8'h00
`define KPM_IDX_RESET 0
`define KPM_VAL_RESET 0

`endif

// [verilog/kpm_pkg.sv]
// Types shared by the keypad parameter menu files.
`default_nettype none

package kpm_pkg;

	// Keypad keys, one bit each, high while pressed.
	typedef struct packed {
		logic start;
		logic stop;
		logic enter;
		logic dir;
		logic up;
		logic down;
	} kpm_keys_t;

	// Menu position, one-hot.
	typedef enum logic [2:0] {
		KPM_OPER = 3'h1,
		KPM_SELECT = 3'h2,
		KPM_EDIT = 3'h4
	} kpm_state_t;

	// Three-position switch of the potentiometer unit.
	typedef enum logic [1:0] {
		KPM_SW_STOP = 2'h0,
		KPM_SW_CW = 2'h1,
		KPM_SW_CCW = 2'h2
	} kpm_pot_sw_t;

endpackage

`default_nettype wire

// [verilog/kpm_debounce.sv]
// Per-key debouncer with a one-cycle press pulse.
`timescale 1ns/1ps
`default_nettype none

module kpm_debounce #(
	parameter int N = 6,
	parameter int CYC = 200000
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [N-1:0] raw,
	output logic [N-1:0] level,
	output logic [N-1:0] press
);

	localparam int CW = $clog2(CYC + 1);

	genvar i;
	generate
		for (i = 0; i < N; i++)
		begin : g_key
			logic [CW-1:0] cnt;
			wire differs = raw[i] != level[i];
			wire settled = cnt == CW'(CYC - 1);

			// A new level is only accepted after it has held for the whole debounce time.
			always_ff @(posedge core_clk or negedge rst_n)
			begin
				if (!rst_n)
				begin
					cnt <= '0;
					level[i] <= 1'b0;
					press[i] <= 1'b0;
				end
				else
				begin
					cnt <= (differs && !settled) ? cnt + 1'b1 : '0;
					if (differs && settled)
						level[i] <= raw[i];
					press[i] <= differs && settled && raw[i];
				end
			end
		end
	endgenerate

endmodule

`default_nettype wire

// [verilog/kpm_menu.sv]
// Keypad parameter menu: mode entry, number scroll, value edit, blink and pot control.
`timescale 1ns/1ps
`default_nettype none
`include "kpm_params.svh"

module kpm_menu #(
	parameter int NUM_PARAMS = `KPM_NUM_PARAMS,
	parameter int VAL_W = `KPM_VAL_W,
	parameter int DEBOUNCE_CYC = `KPM_DEBOUNCE_CYC,
	parameter int CHORD_CYC = `KPM_CHORD_CYC,
	parameter int BLINK_CYC = `KPM_BLINK_CYC
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire kpm_pkg::kpm_keys_t keys_raw,
	input wire logic term_enable,
	input wire logic serial_enable,
	input wire logic drive_running,
	input wire logic [`KPM_SET_W-1:0] control_source_select,
	input wire logic [`KPM_SET_W-1:0] pot_function_select,
	input wire logic [`KPM_FREQ_W-1:0] minimum_output_frequency,
	input wire logic [`KPM_FREQ_W-1:0] maximum_output_frequency,
	input wire logic pot_present,
	input wire kpm_pkg::kpm_pot_sw_t pot_switch,
	input wire logic [`KPM_POS_W-1:0] pot_position,
	input wire logic [VAL_W-1:0] param_rd_value,
	output kpm_pkg::kpm_state_t menu_state,
	output logic [$clog2(NUM_PARAMS)-1:0] param_index,
	output logic [VAL_W-1:0] edit_value,
	output logic disp_blank,
	output logic param_wr,
	output logic [VAL_W-1:0] param_wr_value,
	output logic keypad_run,
	output logic estop,
	output logic pot_enable,
	output logic pot_reverse,
	output logic [`KPM_FREQ_W-1:0] pot_frequency
);

	localparam int IW = $clog2(NUM_PARAMS);
	localparam int WW = $clog2(CHORD_CYC + 1);
	localparam int BW = $clog2(BLINK_CYC + 1);
	localparam int FW = `KPM_FREQ_W;
	localparam int PW = `KPM_POS_W;
	localparam logic [IW-1:0] LAST = IW'(NUM_PARAMS - 1);

	kpm_pkg::kpm_keys_t lvl;
	kpm_pkg::kpm_keys_t prs;

	kpm_debounce #(.N(6), .CYC(DEBOUNCE_CYC)) u_deb (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.raw(keys_raw),
		.level(lvl),
		.press(prs)
	);

	// Chord-capable keys are held back for the window so a chord whose second key lands in a later cycle never fires a single action.
	// Order is start, stop, enter, dir.
	logic [3:0] pend;
	logic [WW-1:0] win_cnt;
	wire [3:0] cap_prs = {prs.start, prs.stop, prs.enter, prs.dir};
	wire [3:0] cap_lvl = {lvl.start, lvl.stop, lvl.enter, lvl.dir};
	wire [3:0] partner = {pend[1], pend[0], pend[3], pend[2]};
	wire chord_hit = |(cap_prs & partner);
	wire pend_lost = (|pend) && (!(|(pend & cap_lvl)) || win_cnt == '0 || (|(cap_prs & ~partner)));
	wire single_fire = pend_lost && !chord_hit;
	wire act_start = single_fire && pend[3];
	wire act_stop = single_fire && pend[2];
	wire act_enter = single_fire && pend[1];
	wire act_dir = single_fire && pend[0];
	wire chord_se = chord_hit && (pend[3] || pend[1]);
	wire chord_sd = chord_hit && (pend[2] || pend[0]);
	wire [3:0] first_prs = cap_prs & (~cap_prs + 4'h1);

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pend <= 4'h0;
			win_cnt <= '0;
		end
		else if (pend == 4'h0 || chord_hit || pend_lost)
		begin
			pend <= (pend == 4'h0) ? first_prs : 4'h0;
			win_cnt <= WW'(CHORD_CYC - 1);
		end
		else
			win_cnt <= win_cnt - 1'b1;
	end

	// Enable sources seen by the menu.
	wire pot_run_sel = pot_switch == kpm_pkg::KPM_SW_CW || pot_switch == kpm_pkg::KPM_SW_CCW;
	wire pot_allowed = pot_present && control_source_select == `KPM_SRC_TERM_KBD;
	wire next_pot_enable = pot_allowed && pot_run_sel;
	wire ext_enable = term_enable || serial_enable || pot_enable;
	wire val_prs = prs.up || prs.down;
	wire val_held = lvl.up || lvl.down;
	wire enter_idle = !keypad_run && !ext_enable && val_prs;
	wire enter_ext = !keypad_run && (term_enable || serial_enable) && drive_running && val_prs;
	wire enter_chord = keypad_run && chord_se;
	wire go_param = enter_idle || enter_ext || enter_chord;

	wire [IW-1:0] idx_up = (param_index == LAST) ? '0 : param_index + 1'b1;
	wire [IW-1:0] idx_dn = (param_index == '0) ? LAST : param_index - 1'b1;
	wire [VAL_W-1:0] val_up = (&edit_value) ? edit_value : edit_value + 1'b1;
	wire [VAL_W-1:0] val_dn = (edit_value == '0) ? edit_value : edit_value - 1'b1;

	// Menu transitions.
	kpm_pkg::kpm_state_t next_state;
	always_comb
	begin
		next_state = menu_state;
		unique case (menu_state)
			kpm_pkg::KPM_OPER:
				if (go_param)
					next_state = kpm_pkg::KPM_SELECT;
			kpm_pkg::KPM_SELECT:
				if (act_start)
					next_state = kpm_pkg::KPM_OPER;
				else if (act_enter)
					next_state = kpm_pkg::KPM_EDIT;
			kpm_pkg::KPM_EDIT:
				if (act_start)
					next_state = kpm_pkg::KPM_OPER;
				else if (act_enter || act_dir)
					next_state = kpm_pkg::KPM_SELECT;
			default:
				next_state = kpm_pkg::KPM_OPER;
		endcase
	end

	wire in_sel = menu_state == kpm_pkg::KPM_SELECT;
	wire in_edit = menu_state == kpm_pkg::KPM_EDIT;
	wire leave_start = !(menu_state == kpm_pkg::KPM_OPER) && act_start;
	wire do_store = in_edit && act_enter && !act_start;

	// Menu state, number and edit value.
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			menu_state <= kpm_pkg::KPM_OPER;
			param_index <= IW'(`KPM_IDX_RESET);
			edit_value <= VAL_W'(`KPM_VAL_RESET);
		end
		else
		begin
			menu_state <= next_state;
			if (in_sel && !leave_start && !act_enter)
				param_index <= prs.up ? idx_up : (prs.down ? idx_dn : param_index);
			if (in_sel && act_enter)
				edit_value <= param_rd_value;
			else if (in_edit)
				edit_value <= prs.up ? val_up : (prs.down ? val_dn : edit_value);
		end
	end

	// A one-cycle write strobe; a discarded edit never raises it.
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			param_wr <= 1'b0;
			param_wr_value <= VAL_W'(`KPM_VAL_RESET);
		end
		else
		begin
			param_wr <= do_store;
			if (do_store)
				param_wr_value <= edit_value;
		end
	end

	// Blink phase from a divider enable; it free-runs so the rhythm stays even.
	logic [BW-1:0] blink_cnt;
	logic blink_phase;
	wire blink_tick = blink_cnt == '0;
	wire dirty = in_edit && edit_value != param_rd_value;
	wire next_blank = dirty && !val_held && blink_phase;

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			blink_cnt <= '0;
			blink_phase <= 1'b0;
			disp_blank <= 1'b0;
		end
		else
		begin
			blink_cnt <= blink_tick ? BW'(BLINK_CYC - 1) : blink_cnt - 1'b1;
			if (blink_tick)
				blink_phase <= !blink_phase;
			disp_blank <= next_blank;
		end
	end

	// Keypad run state; emergency stop takes precedence over everything.
	wire kp_start = menu_state == kpm_pkg::KPM_OPER && act_start && !ext_enable;

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			keypad_run <= 1'b0;
			estop <= 1'b0;
		end
		else
		begin
			estop <= chord_sd;
			if (chord_sd || act_stop)
				keypad_run <= 1'b0;
			else if (kp_start)
				keypad_run <= 1'b1;
		end
	end

	wire [FW-1:0] span = (maximum_output_frequency > minimum_output_frequency) ?
		maximum_output_frequency - minimum_output_frequency : '0;
	wire [FW+PW-1:0] prod = span * pot_position;
	wire [FW+PW-1:0] scaled = prod / (FW + PW)'({PW{1'b1}});
	wire [FW-1:0] mapped = minimum_output_frequency + scaled[FW-1:0];
	wire pot_freq_mode = pot_function_select == `KPM_POT_FUNC_FREQ;

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pot_enable <= 1'b0;
			pot_reverse <= 1'b0;
			pot_frequency <= '0;
		end
		else
		begin
			pot_enable <= next_pot_enable;
			pot_reverse <= pot_switch == kpm_pkg::KPM_SW_CCW;
			pot_frequency <= (pot_freq_mode && pot_allowed) ? mapped : '0;
		end
	end

	a_wrap_fwd: assert property (@(posedge core_clk) disable iff (!rst_n)
		in_sel && prs.up && !act_enter && !act_start && param_index == LAST |=> param_index == '0)
		else $error("forward scroll did not wrap to first");
	a_wrap_back: assert property (@(posedge core_clk) disable iff (!rst_n)
		in_sel && prs.down && !prs.up && !act_enter && !act_start && param_index == '0
		|=> param_index == LAST)
		else $error("backward scroll did not wrap to last");
	a_open_value: assert property (@(posedge core_clk) disable iff (!rst_n)
		in_sel && act_enter && !act_start |=> in_edit && edit_value == $past(param_rd_value))
		else $error("enter did not open stored value");
	a_store_once: assert property (@(posedge core_clk) disable iff (!rst_n)
		do_store |=> param_wr && param_wr_value == $past(edit_value) && in_sel ##1 !param_wr)
		else $error("store strobe wrong");
	a_dir_discard: assert property (@(posedge core_clk) disable iff (!rst_n)
		in_edit && act_dir && !act_enter && !act_start |=> in_sel ##1 !param_wr)
		else $error("direction key stored or stayed");
	a_clean_steady: assert property (@(posedge core_clk) disable iff (!rst_n)
		!dirty |=> !disp_blank)
		else $error("blank without unconfirmed change");
	a_held_steady: assert property (@(posedge core_clk) disable iff (!rst_n)
		val_held |=> !disp_blank)
		else $error("display blinked while value key held");
	a_start_return: assert property (@(posedge core_clk) disable iff (!rst_n)
		leave_start |=> menu_state == kpm_pkg::KPM_OPER)
		else $error("start did not return to operating view");
	a_keypad_locks: assert property (@(posedge core_clk) disable iff (!rst_n)
		menu_state == kpm_pkg::KPM_OPER && keypad_run && !chord_se |=> menu_state == kpm_pkg::KPM_OPER)
		else $error("left operating view without chord");
	a_idle_entry: assert property (@(posedge core_clk) disable iff (!rst_n)
		menu_state == kpm_pkg::KPM_OPER && enter_idle |=> in_sel)
		else $error("value key did not enter parameter mode");
	a_pot_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
		control_source_select != `KPM_SRC_TERM_KBD |=> !pot_enable)
		else $error("pot enable with wrong control source");
	a_estop_kills: assert property (@(posedge core_clk) disable iff (!rst_n)
		chord_sd |=> estop && !keypad_run ##1 !estop || chord_sd)
		else $error("emergency stop chord not acted on");

	c_store: cover property (@(posedge core_clk) disable iff (!rst_n) do_store);
	c_discard: cover property (@(posedge core_clk) disable iff (!rst_n) in_edit && act_dir);
	c_chord_entry: cover property (@(posedge core_clk) disable iff (!rst_n) enter_chord);
	c_blink: cover property (@(posedge core_clk) disable iff (!rst_n) disp_blank);

endmodule

`default_nettype wire

// [verification/kpm_store_model.sv]
// Behavioural parameter store that sits behind the keypad menu.
`timescale 1ns/1ps
`default_nettype none

module kpm_store_model #(
	parameter int NUM_PARAMS = 5,
	parameter int IW = 3
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [IW-1:0] param_index,
	input wire logic param_wr,
	input wire logic [15:0] param_wr_value,
	output logic [15:0] param_rd_value
);
	logic [15:0] mem [NUM_PARAMS];

	// Stored values start distinct per entry so a wrong index shows up at once.
	// storage takes writes
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < NUM_PARAMS; i++)
				mem[i] <= 16'h0100 + 16'(i);
		end
		else if (param_wr)
			mem[param_index] <= param_wr_value;
	end

	// The read is combinational, as the menu expects it in the same cycle.
	assign param_rd_value = mem[param_index];
endmodule

`default_nettype wire

// [verification/tb_kpm_menu.sv]
// Self-checking bench of the keypad parameter menu.
`timescale 1ns/1ps
`default_nettype none

module tb_kpm_menu;
	localparam kpm_pkg::kpm_keys_t k_none = 6'h00;
	localparam kpm_pkg::kpm_keys_t k_start = 6'h20;
	localparam kpm_pkg::kpm_keys_t k_stop = 6'h10;
	localparam kpm_pkg::kpm_keys_t k_enter = 6'h08;
	localparam kpm_pkg::kpm_keys_t k_dir = 6'h04;
	localparam kpm_pkg::kpm_keys_t k_up = 6'h02;
	localparam kpm_pkg::kpm_keys_t k_down = 6'h01;
	logic core_clk, rst_n, term_enable, serial_enable, drive_running, pot_present;
	kpm_pkg::kpm_keys_t keys_raw;
	kpm_pkg::kpm_pot_sw_t pot_switch;
	kpm_pkg::kpm_state_t menu_state;
	logic [7:0] control_source_select, pot_function_select, pot_position;
	logic [15:0] fmin, fmax, rd_value, edit_value, wr_value, pot_frequency;
	logic [2:0] param_index;
	logic disp_blank, param_wr, keypad_run, estop, pot_enable, pot_reverse;
	int error_cnt, n_checks, blank_cnt, wr_cnt, estop_cnt;

	// Short counts keep the run brief; expectations below assume these values.
	kpm_menu #(.NUM_PARAMS(5), .DEBOUNCE_CYC(4), .CHORD_CYC(20), .BLINK_CYC(8)) u_kpm_menu (
		.core_clk(core_clk), .rst_n(rst_n), .keys_raw(keys_raw),
		.term_enable(term_enable), .serial_enable(serial_enable),
		.drive_running(drive_running), .control_source_select(control_source_select),
		.pot_function_select(pot_function_select), .minimum_output_frequency(fmin),
		.maximum_output_frequency(fmax), .pot_present(pot_present),
		.pot_switch(pot_switch), .pot_position(pot_position), .param_rd_value(rd_value),
		.menu_state(menu_state), .param_index(param_index), .edit_value(edit_value),
		.disp_blank(disp_blank), .param_wr(param_wr), .param_wr_value(wr_value),
		.keypad_run(keypad_run), .estop(estop), .pot_enable(pot_enable),
		.pot_reverse(pot_reverse), .pot_frequency(pot_frequency));

	kpm_store_model #(.NUM_PARAMS(5), .IW(3)) u_kpm_store_model (
		.core_clk(core_clk), .rst_n(rst_n), .param_index(param_index),
		.param_wr(param_wr), .param_wr_value(wr_value), .param_rd_value(rd_value));

	// Clock of 100 MHz.
	always #5 core_clk = ~core_clk;

	// Write and stop pulses last one cycle and blanking comes and goes, so they are counted here rather than sampled by the tests.
	always @(posedge core_clk)
	begin
		if (disp_blank === 1'b1) blank_cnt <= blank_cnt + 1;
		if (param_wr === 1'b1) wr_cnt <= wr_cnt + 1;
		if (estop === 1'b1) estop_cnt <= estop_cnt + 1;
	end

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Holds a key long enough to pass the debouncer; k2 joins shortly after to form a chord.
	task automatic press(input kpm_pkg::kpm_keys_t k, input kpm_pkg::kpm_keys_t k2);
		keys_raw = k;
		repeat (3) @(negedge core_clk);
		keys_raw = k | k2;
		repeat (12) @(negedge core_clk);
		keys_raw = k_none;
		repeat (30) @(negedge core_clk);
	endtask

	task automatic t_value_entry;
		press(k_up, k_none);
		chk("state", 16'(kpm_pkg::KPM_SELECT), 16'(menu_state));
		chk("index", 16'h0000, 16'(param_index));
		$display("test value_entry done");
	endtask

	task automatic t_edit_discard;
		press(k_down, k_none);
		chk("index", 16'h0004, 16'(param_index));
		press(k_enter, k_none);
		chk("state", 16'(kpm_pkg::KPM_EDIT), 16'(menu_state));
		chk("edit", 16'h0104, edit_value);
		keys_raw = k_up;
		repeat (10) @(negedge core_clk);
		blank_cnt = 0;
		repeat (30) @(negedge core_clk);
		chk("blank held", 16'h0000, 16'(blank_cnt));
		keys_raw = k_none;
		repeat (10) @(negedge core_clk);
		chk("edit", 16'h0105, edit_value);
		blank_cnt = 0;
		repeat (30) @(negedge core_clk);
		chk("blank idle", 16'h0001, 16'(blank_cnt > 0));
		press(k_dir, k_none);
		chk("state", 16'(kpm_pkg::KPM_SELECT), 16'(menu_state));
		chk("stored", 16'h0104, rd_value);
		chk("writes", 16'h0000, 16'(wr_cnt));
		$display("test edit_discard done");
	endtask

	task automatic t_edit_store;
		press(k_up, k_none);
		chk("index", 16'h0000, 16'(param_index));
		press(k_down, k_none);
		press(k_enter, k_none);
		press(k_up, k_none);
		press(k_enter, k_none);
		chk("writes", 16'h0001, 16'(wr_cnt));
		chk("wr value", 16'h0105, wr_value);
		chk("state", 16'(kpm_pkg::KPM_SELECT), 16'(menu_state));
		chk("stored", 16'h0105, rd_value);
		press(k_start, k_none);
		chk("state", 16'(kpm_pkg::KPM_OPER), 16'(menu_state));
		$display("test edit_store done");
	endtask

	task automatic t_keypad_run;
		press(k_start, k_none);
		chk("run", 16'h0001, 16'(keypad_run));
		press(k_up, k_none);
		chk("state", 16'(kpm_pkg::KPM_OPER), 16'(menu_state));
		press(k_start, k_enter);
		chk("state", 16'(kpm_pkg::KPM_SELECT), 16'(menu_state));
		press(k_start, k_none);
		press(k_stop, k_none);
		chk("run", 16'h0000, 16'(keypad_run));
		press(k_stop, k_dir);
		chk("estops", 16'h0001, 16'(estop_cnt));
		$display("test keypad_run done");
	endtask

	task automatic t_external;
		term_enable = 1'b1;
		press(k_up, k_none);
		chk("state", 16'(kpm_pkg::KPM_OPER), 16'(menu_state));
		drive_running = 1'b1;
		press(k_up, k_none);
		chk("state", 16'(kpm_pkg::KPM_SELECT), 16'(menu_state));
		press(k_start, k_none);
		term_enable = 1'b0;
		serial_enable = 1'b1;
		press(k_down, k_none);
		chk("state", 16'(kpm_pkg::KPM_SELECT), 16'(menu_state));
		press(k_start, k_none);
		serial_enable = 1'b0;
		drive_running = 1'b0;
		$display("test external done");
	endtask

	task automatic t_pot;
		pot_present = 1'b1;
		pot_switch = kpm_pkg::KPM_SW_CW;
		pot_position = 8'h80;
		repeat (3) @(negedge core_clk);
		chk("pot en", 16'h0001, 16'(pot_enable));
		chk("pot rev", 16'h0000, 16'(pot_reverse));
		chk("pot freq", 16'h00e4, pot_frequency);
		pot_switch = kpm_pkg::KPM_SW_CCW;
		pot_position = 8'hff;
		repeat (3) @(negedge core_clk);
		chk("pot rev", 16'h0001, 16'(pot_reverse));
		chk("pot freq", 16'h0163, pot_frequency);
		{fmin, fmax} = {16'h0200, 16'h0100};
		repeat (3) @(negedge core_clk);
		chk("pot freq", 16'h0200, pot_frequency);
		pot_function_select = 8'h01;
		repeat (3) @(negedge core_clk);
		chk("pot freq", 16'h0000, pot_frequency);
		control_source_select = 8'h01;
		repeat (3) @(negedge core_clk);
		chk("pot en", 16'h0000, 16'(pot_enable));
		control_source_select = 8'h00;
		pot_switch = kpm_pkg::KPM_SW_STOP;
		repeat (3) @(negedge core_clk);
		chk("pot en", 16'h0000, 16'(pot_enable));
		$display("test pot done");
	endtask

	task automatic close_out;
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Main sequence: reset for three cycles, then each scenario in turn.
	initial
	begin
		{core_clk, rst_n, term_enable, serial_enable, drive_running, pot_present} = 6'h00;
		{keys_raw, control_source_select, pot_function_select, pot_position} = 30'h0;
		{fmin, fmax} = {16'h0064, 16'h0163};
		pot_switch = kpm_pkg::KPM_SW_STOP;
		{error_cnt, n_checks, blank_cnt, wr_cnt, estop_cnt} = '0;
		repeat (3) @(negedge core_clk);
		rst_n = 1'b1;
		@(negedge core_clk);
		t_value_entry();
		t_edit_discard();
		t_edit_store();
		t_keypad_run();
		t_external();
		t_pot();
		close_out();
	end

	// Watchdog well beyond the roughly one thousand cycles the scenarios need.
	initial
	begin
		repeat (20000) @(posedge core_clk);
		error_cnt++;
		close_out();
	end
endmodule

`default_nettype wire
